// ==== inc/motor_comp_pkg.sv ====
// Notes on behaviour
// - Hold system resistance, 0 to 800 milliohm, default 50, for compensation only.
// - Load compensation resistance is a percentage of system resistance, default 70.
// - Throttle neutral near zero speed applies rollback percentage, up to 125, default 90.
// - Sensor enabled takes pulses from analog input six; disabled by default.
// - While sensor enabled, switch six reads off whatever its pin level.
// - Speed limiting, on by default, holds measured speed at or below maximum only while the sensor is also enabled.
// - Encoder fault when duty exceeds threshold, default 25, and no pulses arrive.
// - Speed uses pulses per revolution, 1 to 32, default 16.
// - Maximum speed 100 to 6000 rpm, default 3000, is the limit target; writes are not clamped to that range.
// - Proportional gain, default 20, scales the limit correction.
// - Integral gain, default 20, drives steady error to zero at maximum speed.
//
// Purpose: Shared constants and types of the motor compensation and speed limit block.
// Assumes: AXI4-Lite register access with 32-bit data, one clock.
// Notes:   Percent scaling uses a multiply by 656 and a shift by 16.
package motor_comp_pkg;
    localparam int CLK_HZ            = 250_000_000;
    localparam int SAMPLE_US         = 10_000;
    localparam int SAMPLE_CYCLES_DEF = CLK_HZ / 1_000_000 * SAMPLE_US;
    localparam int SEC_PER_MIN       = 60;

    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_SYS_RES = 8'h04;
    localparam logic [7:0] OFS_LOAD    = 8'h08;
    localparam logic [7:0] OFS_ROLL    = 8'h0c;
    localparam logic [7:0] OFS_ENC_THR = 8'h10;
    localparam logic [7:0] OFS_PPR     = 8'h14;
    localparam logic [7:0] OFS_MAX_RPM = 8'h18;
    localparam logic [7:0] OFS_KP      = 8'h1c;
    localparam logic [7:0] OFS_KI      = 8'h20;
    localparam logic [7:0] OFS_RPM     = 8'h24;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h28;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h2c;
    localparam logic [7:0] OFS_COMP    = 8'h30;
    localparam logic [7:0] OFS_DUTY    = 8'h34;

    localparam int CTRL_SENSOR_BIT = 0;
    localparam int CTRL_LIMIT_BIT  = 1;
    localparam int IRQ_ENC_BIT     = 0;
    localparam int IRQ_LIMIT_BIT   = 1;
    localparam int IRQ_SAMPLE_BIT  = 2;
    localparam int IRQ_W           = 3;

    localparam logic [1:0]  CTRL_RST    = 2'h2;
    localparam logic [9:0]  SYS_RES_RST = 10'h032;
    localparam logic [9:0]  SYS_RES_MAX = 10'h320;
    localparam logic [6:0]  LOAD_RST    = 7'h46;
    localparam logic [6:0]  ROLL_RST    = 7'h5a;
    localparam logic [6:0]  ENC_THR_RST = 7'h19;
    localparam logic [5:0]  PPR_RST     = 6'h10;
    localparam logic [5:0]  PPR_MIN     = 6'h01;
    localparam logic [5:0]  PPR_MAX     = 6'h20;
    localparam logic [12:0] MAX_RPM_RST = 13'h0bb8;
    localparam logic [6:0]  KP_RST      = 7'h14;
    localparam logic [6:0]  KI_RST      = 7'h14;
    localparam logic [6:0]  LOAD_MAX    = 7'h64;
    localparam logic [6:0]  ROLL_MAX    = 7'h7d;
    localparam logic [12:0] NEAR_ZERO_RPM = 13'h0032;
    localparam logic [12:0] RPM_SAT     = 13'h1fff;
    localparam logic [6:0]  DUTY_FULL   = 7'h64;

    localparam int PCT_MUL    = 656;
    localparam int PCT_SHIFT  = 16;
    localparam int CORR_SHIFT = 6;
    localparam logic signed [23:0] INTEG_MAX = 24'sh03ffff;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int DIV_W  = 40;
    localparam int DVSR_W = 6;

    typedef struct packed {
        logic [DIV_W-1:0]  dividend;
        logic [DVSR_W-1:0] divisor;
    } div_req_t;

    typedef enum logic [1:0] {MEAS_WAIT, MEAS_START, MEAS_DIV, MEAS_LOOP} meas_state_t;
endpackage

// ==== rtl/rpm_divider.sv ====
// Purpose: Restoring divider that turns an edge product into rpm.
// Assumes: Divisor is never zero; the caller clamps it.
// Notes:   One quotient bit per clock, so a result takes DIV_W cycles.
`timescale 1ns/100ps
module rpm_divider (
    input  wire logic                                aclk,
    input  wire logic                                aresetn,
    input  wire logic                                start,
    input  wire motor_comp_pkg::div_req_t            req,
    output logic                                     done,
    output logic [motor_comp_pkg::DIV_W-1:0]         quotient
);
    import motor_comp_pkg::*;

    logic [DVSR_W:0]  rem;
    logic [DVSR_W-1:0] dvsr;
    logic [DIV_W-1:0] shreg;
    logic [5:0]       count;
    logic             busy;
    logic [DVSR_W:0]  trial;

    always_comb begin
        trial = {rem[DVSR_W-1:0], shreg[DIV_W-1]};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rem      <= '0;
            dvsr     <= '0;
            shreg    <= '0;
            count    <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
            quotient <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem   <= '0;
                dvsr  <= req.divisor;
                shreg <= req.dividend;
                count <= 6'(DIV_W);
                busy  <= 1'b1;
            end else if (busy) begin
                if (trial >= {1'b0, dvsr}) begin
                    rem   <= trial - {1'b0, dvsr};
                    shreg <= {shreg[DIV_W-2:0], 1'b1};
                end else begin
                    rem   <= trial;
                    shreg <= {shreg[DIV_W-2:0], 1'b0};
                end
                count <= count - 6'h01;
                if (count == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quotient <= (trial >= {1'b0, dvsr}) ? {shreg[DIV_W-2:0], 1'b1}
                                                        : {shreg[DIV_W-2:0], 1'b0};
                end
            end
        end
    end
endmodule

// ==== rtl/motor_comp_speed_limit.sv ====
// Purpose: Load and rollback compensation, pulse speed sensing and a PI speed limit.
// Assumes: duty_cmd is a percentage no larger than 100; analog6_data is on aclk.
// Notes:   Speed refreshes once per sample window; the loop reacts no faster.
`timescale 1ns/100ps
module motor_comp_speed_limit #(
    parameter int SAMPLE_CYCLES = motor_comp_pkg::SAMPLE_CYCLES_DEF
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        analog6_pin,
    input  wire logic [11:0] analog6_data,
    input  wire logic        switch6_pin,
    input  wire logic        throttle_neutral,
    input  wire logic [6:0]  duty_cmd,
    output logic [11:0]      analog6_value,
    output logic             switch6_state,
    output logic [6:0]       duty_out,
    output logic [9:0]       comp_res_mohm,
    output logic             encoder_fault,
    output logic             irq
);
    import motor_comp_pkg::*;

    localparam logic [31:0] WIN_LAST  = 32'(SAMPLE_CYCLES - 1);
    localparam logic [23:0] RPM_SCALE = 24'(SEC_PER_MIN * (CLK_HZ / SAMPLE_CYCLES));

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and interrupt state.

    logic [1:0]        ctrl;
    logic [9:0]        sys_res;
    logic [6:0]        load_pct;
    logic [6:0]        roll_pct;
    logic [6:0]        enc_thr;
    logic [5:0]        ppr;
    logic [12:0]       max_rpm;
    logic [6:0]        speed_limit_prop_gain;
    logic [6:0]        speed_limit_int_gain;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_events;

    logic              sensor_en;
    logic              limit_en;

    assign sensor_en = ctrl[CTRL_SENSOR_BIT];
    assign limit_en  = ctrl[CTRL_LIMIT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.

    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        aw_full;
    logic        w_full;
    logic        do_write;
    logic        wr_hit;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign do_write = aw_full && w_full && !s_axi_bvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                aw_full       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                w_full       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_comb begin
        case (wr_addr)
            OFS_CTRL, OFS_SYS_RES, OFS_LOAD, OFS_ROLL, OFS_ENC_THR, OFS_PPR,
            OFS_MAX_RPM, OFS_KP, OFS_KI, OFS_IRQ_ST, OFS_IRQ_MSK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    logic [12:0] rpm;

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFS_CTRL:    rd_word = {30'h0, ctrl};
            OFS_SYS_RES: rd_word = {22'h0, sys_res};
            OFS_LOAD:    rd_word = {25'h0, load_pct};
            OFS_ROLL:    rd_word = {25'h0, roll_pct};
            OFS_ENC_THR: rd_word = {25'h0, enc_thr};
            OFS_PPR:     rd_word = {26'h0, ppr};
            OFS_MAX_RPM: rd_word = {19'h0, max_rpm};
            OFS_KP:      rd_word = {25'h0, speed_limit_prop_gain};
            OFS_KI:      rd_word = {25'h0, speed_limit_int_gain};
            OFS_RPM:     rd_word = {19'h0, rpm};
            OFS_IRQ_ST:  rd_word = {29'h0, irq_status};
            OFS_IRQ_MSK: rd_word = {29'h0, irq_mask};
            OFS_COMP:    rd_word = {22'h0, comp_res_mohm};
            OFS_DUTY:    rd_word = {24'h0, encoder_fault, duty_out};
            default: begin
                rd_word = 32'h0;
                rd_hit  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes. Resistance, load, rollback and ppr values are clamped so the math stays sane.

    logic [31:0] wv;

    always_comb begin
        case (wr_addr)
            OFS_CTRL:    wv = merge({30'h0, ctrl}, wr_data, wr_strb);
            OFS_SYS_RES: wv = merge({22'h0, sys_res}, wr_data, wr_strb);
            OFS_PPR:     wv = merge({26'h0, ppr}, wr_data, wr_strb);
            OFS_MAX_RPM: wv = merge({19'h0, max_rpm}, wr_data, wr_strb);
            default:     wv = merge(32'h0, wr_data, wr_strb);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl                  <= CTRL_RST;
            sys_res               <= SYS_RES_RST;
            load_pct              <= LOAD_RST;
            roll_pct              <= ROLL_RST;
            enc_thr               <= ENC_THR_RST;
            ppr                   <= PPR_RST;
            max_rpm               <= MAX_RPM_RST;
            speed_limit_prop_gain <= KP_RST;
            speed_limit_int_gain  <= KI_RST;
            irq_mask              <= '0;
        end else if (do_write && wr_strb != 4'h0) begin
            case (wr_addr)
                OFS_CTRL:    ctrl <= wv[1:0];
                OFS_SYS_RES: sys_res <= (wv[31:0] > 32'(SYS_RES_MAX)) ? SYS_RES_MAX
                                                                      : wv[9:0];
                OFS_LOAD:    if (wr_strb[0]) load_pct <= (wv > 32'(LOAD_MAX)) ? LOAD_MAX
                                                                             : wv[6:0];
                OFS_ROLL:    if (wr_strb[0]) roll_pct <= (wv > 32'(ROLL_MAX)) ? ROLL_MAX
                                                                             : wv[6:0];
                OFS_ENC_THR: if (wr_strb[0]) enc_thr <= wv[6:0];
                OFS_PPR: begin
                    if (wv[31:0] < 32'(PPR_MIN))      ppr <= PPR_MIN;
                    else if (wv[31:0] > 32'(PPR_MAX)) ppr <= PPR_MAX;
                    else                              ppr <= wv[5:0];
                end
                OFS_MAX_RPM: max_rpm <= wv[12:0];
                OFS_KP:      if (wr_strb[0]) speed_limit_prop_gain <= wv[6:0];
                OFS_KI:      if (wr_strb[0]) speed_limit_int_gain <= wv[6:0];
                OFS_IRQ_MSK: if (wr_strb[0]) irq_mask <= wv[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
        end else if (do_write && wr_addr == OFS_IRQ_ST && wr_strb[0]) begin
            irq_status <= (irq_status & ~wr_data[IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) irq <= 1'b0;
        else          irq <= |(irq_status & irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and shared analog six / switch six use.

    logic [1:0] pulse_sync;
    logic [1:0] sw_sync;
    logic       pulse_prev;
    logic       pulse_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_sync <= '0;
            sw_sync    <= '0;
            pulse_prev <= 1'b0;
        end else begin
            pulse_sync <= {pulse_sync[0], analog6_pin};
            sw_sync    <= {sw_sync[0], switch6_pin};
            pulse_prev <= pulse_sync[1];
        end
    end

    assign pulse_edge = sensor_en && pulse_sync[1] && !pulse_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog6_value <= '0;
            switch6_state <= 1'b0;
        end else begin
            analog6_value <= sensor_en ? 12'h000 : analog6_data;
            switch6_state <= sensor_en ? 1'b0 : sw_sync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Speed measurement: edges per window, then edges * scale / ppr.

    meas_state_t state;
    logic [31:0] win_cnt;
    logic [15:0] edge_cnt;
    logic [15:0] edges_last;
    logic        win_end;
    logic        div_done;
    logic [DIV_W-1:0] div_q;
    div_req_t    div_req;

    assign win_end = (win_cnt == WIN_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_cnt    <= '0;
            edge_cnt   <= '0;
            edges_last <= '0;
        end else if (win_end) begin
            win_cnt    <= '0;
            edges_last <= edge_cnt;
            edge_cnt   <= {15'h0, pulse_edge};
        end else begin
            win_cnt <= win_cnt + 32'h1;
            if (pulse_edge && edge_cnt != 16'hffff) edge_cnt <= edge_cnt + 16'h1;
        end
    end

    assign div_req.dividend = 40'(edges_last * RPM_SCALE);
    assign div_req.divisor  = ppr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= MEAS_WAIT;
            rpm   <= '0;
        end else begin
            case (state)
                MEAS_WAIT:  if (win_end) state <= MEAS_START;
                MEAS_START: state <= MEAS_DIV;
                MEAS_DIV: begin
                    if (div_done) begin
                        rpm   <= (div_q > 40'(RPM_SAT)) ? RPM_SAT : div_q[12:0];
                        state <= MEAS_LOOP;
                    end
                end
                MEAS_LOOP:  state <= MEAS_WAIT;
                default:    state <= MEAS_WAIT;
            endcase
        end
    end

    rpm_divider u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (state == MEAS_START),
        .req      (div_req),
        .done     (div_done),
        .quotient (div_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // PI speed limit, updated once per speed sample. It only ever removes duty.

    logic signed [14:0] err;
    logic signed [35:0] p_term;
    logic signed [35:0] i_term;
    logic signed [23:0] integ;
    logic signed [35:0] integ_sum;
    logic signed [35:0] corr;
    logic [6:0]         reduce;
    logic [6:0]         next_reduce;
    logic signed [23:0] next_integ;

    always_comb begin
        err       = $signed({2'b00, rpm}) - $signed({2'b00, max_rpm});
        p_term    = (36'(err) * $signed({1'b0, speed_limit_prop_gain})
                     * 36'sd656) >>> PCT_SHIFT;
        i_term    = (36'(err) * $signed({1'b0, speed_limit_int_gain})
                     * 36'sd656) >>> PCT_SHIFT;
        integ_sum = 36'(integ) + i_term;
        if (integ_sum < 0)                   next_integ = 24'sh0;
        else if (integ_sum > 36'(INTEG_MAX)) next_integ = INTEG_MAX;
        else                                 next_integ = integ_sum[23:0];
        corr = (p_term + 36'(next_integ)) >>> CORR_SHIFT;
        if (corr <= 0)                    next_reduce = 7'h00;
        else if (corr > 36'(DUTY_FULL))   next_reduce = DUTY_FULL;
        else                              next_reduce = corr[6:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            integ  <= '0;
            reduce <= '0;
        end else if (!(limit_en && sensor_en)) begin
            integ  <= '0;
            reduce <= '0;
        end else if (state == MEAS_LOOP) begin
            integ  <= next_integ;
            reduce <= next_reduce;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) duty_out <= '0;
        else          duty_out <= (duty_cmd > reduce) ? duty_cmd - reduce : 7'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compensation resistance and encoder fault.

    logic [16:0] load_mul;
    logic [16:0] roll_mul;
    logic [26:0] pct_res;

    always_comb begin
        load_mul = 17'(sys_res * load_pct);
        roll_mul = 17'(sys_res * roll_pct);
        if (throttle_neutral && rpm < NEAR_ZERO_RPM) pct_res = 27'(roll_mul * 27'(PCT_MUL));
        else                                         pct_res = 27'(load_mul * 27'(PCT_MUL));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_res_mohm <= '0;
            encoder_fault <= 1'b0;
        end else begin
            comp_res_mohm <= pct_res[25:16];
            encoder_fault <= sensor_en && edges_last == 16'h0 && duty_out > enc_thr;
        end
    end

    logic fault_now;
    logic limit_prev;

    assign fault_now = sensor_en && edges_last == 16'h0 && duty_out > enc_thr;

    always_ff @(posedge aclk) begin
        if (!aresetn) limit_prev <= 1'b0;
        else          limit_prev <= reduce != 7'h00;
    end

    assign irq_events[IRQ_ENC_BIT]    = fault_now && !encoder_fault;
    assign irq_events[IRQ_LIMIT_BIT]  = reduce != 7'h00 && !limit_prev;
    assign irq_events[IRQ_SAMPLE_BIT] = state == MEAS_LOOP;
endmodule

// ==== verification/pulse_sensor_model.sv ====
// Purpose: Speed sensor on the far side, a square wave of 20-cycle halves.
// Assumes: Runs only when asked; the pin stands low otherwise.
// Notes:   Far too fast for a 2500-cycle window, so measured speed saturates.
`timescale 1ns/100ps
module pulse_sensor_model (
    input  wire logic aclk,
    input  wire logic run,
    output logic      pulse
);
    logic [4:0] cnt = 5'h00;
    always @(posedge aclk) begin
        cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
        if (!run) pulse <= 1'b0;
        else if (cnt == 5'h13) pulse <= !pulse;
    end
endmodule

// ==== verification/motor_comp_props.sv ====
// Purpose: Port properties of the compensation and speed limit block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   A fault implies sensor on, the only sensor state seen at the ports.
`timescale 1ns/100ps
module motor_comp_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [6:0]  duty_cmd,
    input wire logic [6:0]  duty_out,
    input wire logic [9:0]  comp_res_mohm,
    input wire logic [11:0] analog6_value,
    input wire logic        switch6_state,
    input wire logic        encoder_fault
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence r_done;
        s_axi_rvalid && s_axi_rready;
    endsequence
    AST_SWF: assert property (encoder_fault |-> !switch6_state) else $error("switch on");
    AST_ANF: assert property (encoder_fault |-> analog6_value == 12'h000) else $error("analog");
    AST_DTY: assert property (duty_out <= $past(duty_cmd)) else $error("duty raised");
    AST_CMP: assert property (comp_res_mohm <= 10'h3e8) else $error("comp too big");
    AST_ARD: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready) else $error("no rdata");
    AST_RDN: assert property (r_done |=> !s_axi_rvalid) else $error("read held");
    AST_BDN: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b held");
    AST_ARL: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read reopened");
endmodule
bind motor_comp_speed_limit motor_comp_props motor_comp_props_inst (.*);

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench of the compensation and speed limit block.
// Assumes: A 2500-cycle window, so one pulse edge saturates the speed.
// Notes:   Limit figures follow the integrator filling over three windows.
`timescale 1ns/100ps
module testbench;
    import motor_comp_pkg::*;
    localparam int WIN = 2500;
    logic aclk, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, switch6_pin = 1, throttle_neutral = 0, run = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic analog6_pin, switch6_state, encoder_fault, irq;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [11:0] analog6_data = 12'h5a5, analog6_value;
    logic [6:0]  duty_cmd = 0, duty_out;
    logic [9:0]  comp_res_mohm;
    int miscompares = 0, checked = 0, cycles = 0;
    motor_comp_speed_limit #(.SAMPLE_CYCLES(WIN)) motor_comp_speed_limit_inst (.*);
    pulse_sensor_model pulse_sensor_model_inst (.aclk, .run, .pulse(analog6_pin));
    initial begin
        aclk = 0;
        forever #2 aclk = !aclk;
    end
    task automatic conclude;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Each channel drops its valid at the edge that takes it; ends on the answer.
    task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
        {s_axi_arvalid, s_axi_rready} <= {2{!we}};
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (we ? s_axi_bvalid : s_axi_rvalid) break;
        end
        q = s_axi_rdata;
        r = we ? s_axi_bresp : s_axi_rresp;
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask
    task automatic t_defaults;
        logic [31:0] e [9] = '{32'h2, 32'h32, 32'h46, 32'h5a, 32'h19, 32'h10, 32'hbb8, 32'h14, 32'h14};
        for (int i = 0; i < 9; i++) begin
            axi(0, 8'(i * 4), 32'h0);
            chk(q, e[i]);
        end
    endtask
    task automatic t_comp;
        axi(1, OFS_SYS_RES, 32'h384);
        axi(0, OFS_SYS_RES, 32'h0);
        chk(q, 32'h320);
        chk(32'(comp_res_mohm), 32'h230);
        chk(32'(analog6_value), 32'h5a5);
        chk(32'(switch6_state), 32'h1);
        throttle_neutral <= 1'b1;
        axi(1, OFS_ROLL, 32'h7f);
        cyc(10);
        chk(32'(comp_res_mohm), 32'h3e8);
        throttle_neutral <= 1'b0;
        axi(1, OFS_RPM, 32'h5);
        chk(32'(r), 32'(RESP_SLVERR));
        axi(0, 8'hfc, 32'h0);
        chk(q, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
    endtask
    task automatic t_sensor;
        duty_cmd <= 7'h32;
        axi(1, OFS_IRQ_MSK, 32'h1);
        axi(1, OFS_CTRL, 32'h3);
        cyc(5);
        chk(32'(analog6_value), 32'h0);
        chk(32'(switch6_state), 32'h0);
        chk(32'(duty_out), 32'h32);
        cyc(3 * WIN);
        chk(32'({encoder_fault, irq}), 32'h3);
        axi(1, OFS_IRQ_ST, 32'h1);
        cyc(3);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_limit;
        run <= 1'b1;
        cyc(2 * WIN + 100);
        axi(0, OFS_RPM, 32'h0);
        chk(q, 32'h1fff);
        chk(32'(encoder_fault), 32'h0);
        cyc(8 * WIN);
        chk(32'(duty_out), 32'h0);
        axi(0, OFS_IRQ_ST, 32'h0);
        chk(q, 32'h6);
        axi(1, OFS_CTRL, 32'h1);
        cyc(5);
        chk(32'(duty_out), 32'h32);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_defaults();
        t_comp();
        t_sensor();
        t_limit();
        conclude();
    end
endmodule
